// ==== core/eie_map.vh ====
/*
  Constants of the serial EEPROM instruction engine: select codes, address
  fields, identification page layout and program-cycle timing.
  Assumes it is included by bare name from the design files under core/.
*/
// How it works
// - A separate 128-byte identification page sits beside the main array.
// - Page bytes 00h-02h hold preset codes; all bytes writable while unlocked.
// - Write: start, select with direction 0, high then low address byte.
// - Programming starts only on a stop right after a data byte ack.
// - While programming, the data line is released and all requests ignored.
// - After programming the counter points past the last modified byte.
// - Write-protect high: data bytes get no ack, memory unchanged.
// - Page write keeps A15..A7, extra bytes wrap and overwrite the page start.
// - Byte counter advances after each taken data byte, wrapping inside the page.
// - Id page write: type 1011b, A10 zero, A6..A0 pick the byte.
// - Locked id page: data bytes of an id page write get no ack.
// - Lock: type 1011b, A10 one, data bit 1 set, page then read-only.
// - Select byte gets no ack while busy and an ack once done.
// - Reads behave the same whatever the write-protect level.
// - Random read: address write, repeated start, select with direction 1.
// - Select with direction 1 alone reads at the counter then increments it.
// - One counter serves array and id page; id accesses load the page byte.
// - Bytes keep coming while the master acks; no ack then stop ends it.
// - Sequential array reads wrap from the last address to 00h.
// - Id page read: random read format with type 1011b, A6..A0 used.
// - Id page write with one byte acks if unlocked, no ack if locked.
// - A start cancels a pending command; a stop returns to standby.
// - Select acked only for type 1010b or 1011b and matching chip-select bits.
// - After eight bits the receiver pulls data low in the ninth clock.
// - Master leaving the ninth bit high during a read ends the read.
`ifndef EIE_MAP_VH
`define EIE_MAP_VH

// Select byte device types
`define EIE_TYPE_ARR   4'hA
`define EIE_TYPE_ID    4'hB

// Address field positions
`define EIE_A10_BIT    2
`define EIE_LOCK_BIT   1
`define EIE_PAGE_BYTES 128

// Bit slot counter values
`define EIE_SLOT_ACK   4'h8
`define EIE_SLOT_DONE  4'h9

// Id page preset codes (values arbitrary)
`define EIE_IDC_MFR    8'h5A
`define EIE_IDC_FAM    8'h3C
`define EIE_IDC_DEN    8'h81

// Program cycle timing
`define EIE_PROG_US    5000
`define EIE_CLK_MHZ    25
`define EIE_PROG_CYC   (`EIE_PROG_US * `EIE_CLK_MHZ)

`endif

// ==== core/eie_sync.v ====
/*
  Two-stage synchroniser for pin inputs of the EEPROM engine.
  Assumes inputs are asynchronous to i_core_clk; idle level is high.
*/
`timescale 1ns/1ns
`default_nettype none

module eie_sync #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         i_core_clk,
  input  wire         i_rst,
  input  wire         i_ce,
  // Pins in, synchronised out
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);

  reg [W-1:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= {W{1'b1}};
      o_sync <= {W{1'b1}};
    end else if (i_ce) begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ==== core/eie_engine.v ====
/*
  Instruction engine of a two-wire serial EEPROM slave: 64-Kbyte array,
  128-byte lockable identification page, page buffer and program cycle.
  Assumes the bus master drives the serial clock; the data pin is open
  drain, resolved outside from o_sda_oe. i_rst stands for power-on reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "eie_map.vh"

module eie_engine #(
  parameter PROG_CYC = `EIE_PROG_CYC
) (
  // Clock, reset, clock enable
  input  wire i_core_clk,
  input  wire i_rst,
  input  wire i_ce,
  // Serial bus pins
  input  wire i_scl,
  input  wire i_sda,
  output reg  o_sda_out,
  output reg  o_sda_oe,
  // Strap pins
  input  wire i_write_protect_input,
  input  wire i_chip_select_bit2,
  input  wire i_chip_select_bit1,
  input  wire i_chip_select_bit0,
  // Status
  output reg  o_busy,
  output reg  o_id_locked
);

  // Sequencer states: idle, select byte, two address bytes,
  // write data, read data and the program cycle that ignores the bus
  localparam ST_IDLE = 3'h0;
  localparam ST_DEV  = 3'h1;
  localparam ST_AH   = 3'h2;
  localparam ST_AL   = 3'h3;
  localparam ST_WD   = 3'h4;
  localparam ST_RD   = 3'h5;
  localparam ST_BUSY = 3'h6;

  // Last count of the program cycle; PROG_CYC must fit in 20 bits
  localparam [19:0] PROG_LAST = PROG_CYC - 1;

  // Synchronised pins, sequencer registers and the three memories.
  // pbuf holds one page of incoming bytes; mask_q marks which of
  // them were taken, so only those reach the array or id page at commit time.
  wire [5:0]   sy;
  reg  [2:0]   state_q;
  reg  [3:0]   bit_q;
  reg  [7:0]   sh_q;
  reg  [7:0]   ahi_q;
  reg  [7:0]   rdat_q;
  reg  [15:0]  addr_q;
  reg  [8:0]   page_q;
  reg          id_q;
  reg          rw_q;
  reg          mack_q;
  reg          scl_q;
  reg          sda_q;
  reg  [127:0] mask_q;
  reg          lockp_q;
  reg  [19:0]  cnt_q;
  reg  [7:0]   mem   [0:65535];
  reg  [7:0]   idpg  [0:127];
  reg  [7:0]   pbuf  [0:127];
  integer      k;

  // Pins through two flip-flops
  eie_sync #(.W(6)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_async    ({i_chip_select_bit2, i_chip_select_bit1, i_chip_select_bit0,
                  i_write_protect_input, i_sda, i_scl}),
    .o_sync     (sy)
  );

  wire       scl_s = sy[0];
  wire       sda_s = sy[1];
  wire       wp_s  = sy[2];
  wire [2:0] cs_s  = sy[5:3];

  // Bus events seen on the core clock
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
  wire in_frame  = (state_q != ST_IDLE) && (state_q != ST_BUSY);
  wire ack_edge  = scl_fall && (bit_q == `EIE_SLOT_ACK) && !bus_start && !bus_stop;

  // Select byte decode
  wire sel_hit = ((sh_q[7:4] == `EIE_TYPE_ARR) || (sh_q[7:4] == `EIE_TYPE_ID))
                 && (sh_q[3:1] == cs_s);

  // Data byte may be taken: not protected and page not locked
  wire lock_cmd = id_q && ahi_q[`EIE_A10_BIT];
  wire take_ok  = !wp_s && !(id_q && o_id_locked);
  wire buf_we   = (state_q == ST_WD) && ack_edge && take_ok && !lock_cmd;

  // Read data at the shared counter
  wire [7:0] rd_byte = id_q ? idpg[addr_q[6:0]] : mem[addr_q];

  // Next counter value after a read byte
  wire [15:0] rd_next = id_q ? {9'h000, addr_q[6:0] + 7'h01} : addr_q + 16'h0001;

  // Commit slot during the program cycle
  wire       cm_on = (state_q == ST_BUSY) && (cnt_q < `EIE_PAGE_BYTES);
  wire [6:0] ci    = cnt_q[6:0];

  // Instruction sequencer
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q   <= ST_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      ahi_q     <= 8'h00;
      rdat_q    <= 8'h00;
      addr_q    <= 16'h0000;
      page_q    <= 9'h000;
      id_q      <= 1'b0;
      rw_q      <= 1'b0;
      mack_q    <= 1'b1;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      mask_q    <= 128'h0;
      lockp_q   <= 1'b0;
      cnt_q     <= 20'h00000;
      o_sda_out <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_busy    <= 1'b0;
    end else if (i_ce) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (state_q == ST_BUSY) begin
        // Bus ignored and line released while programming
        o_sda_oe <= 1'b0;
        cnt_q    <= cnt_q + 20'h00001;
        if (cnt_q == PROG_LAST) begin
          state_q <= ST_IDLE;
          o_busy  <= 1'b0;
          mask_q  <= 128'h0;
          lockp_q <= 1'b0;
        end
      end else if (bus_start) begin
        // Start or repeated start drops any pending command
        state_q  <= ST_DEV;
        bit_q    <= 4'h0;
        o_sda_oe <= 1'b0;
        mask_q   <= 128'h0;
        lockp_q  <= 1'b0;
      end else if (bus_stop) begin
        o_sda_oe <= 1'b0;
        if ((state_q == ST_WD) && (bit_q <= 4'h1) && ((|mask_q) || lockp_q)) begin
          state_q <= ST_BUSY;
          o_busy  <= 1'b1;
          cnt_q   <= 20'h00000;
        end else begin
          state_q <= ST_IDLE;
          mask_q  <= 128'h0;
          lockp_q <= 1'b0;
        end
      end else if (in_frame && scl_rise) begin
        // Sample on the rising clock edge
        if (bit_q < `EIE_SLOT_ACK) begin
          sh_q <= {sh_q[6:0], sda_s};
        end else begin
          mack_q <= sda_s;
        end
        bit_q <= bit_q + 4'h1;
      end else if (in_frame && scl_fall) begin
        case (bit_q)
          `EIE_SLOT_ACK: begin
            case (state_q)
              ST_DEV: begin
                if (sel_hit) begin
                  o_sda_oe <= 1'b1;
                  id_q     <= sh_q[4];
                  rw_q     <= sh_q[0];
                end else begin
                  state_q <= ST_IDLE;
                end
              end
              ST_AH: begin
                ahi_q    <= sh_q;
                o_sda_oe <= 1'b1;
              end
              ST_AL: begin
                o_sda_oe <= 1'b1;
                // Page is A15..A7 of the address; unused for id accesses
                page_q   <= {ahi_q, sh_q[7]};
                if (id_q) begin
                  addr_q <= {9'h000, sh_q[6:0]};
                end else begin
                  addr_q <= {ahi_q, sh_q};
                end
              end
              ST_WD: begin
                o_sda_oe <= take_ok;
                if (take_ok && lock_cmd) begin
                  lockp_q <= lockp_q | sh_q[`EIE_LOCK_BIT];
                end
                if (buf_we) begin
                  mask_q[addr_q[6:0]] <= 1'b1;
                  addr_q <= {addr_q[15:7], addr_q[6:0] + 7'h01};
                end
              end
              default: begin
                o_sda_oe <= 1'b0;                               // Master acks a read byte
              end
            endcase
          end
          `EIE_SLOT_DONE: begin
            o_sda_oe <= 1'b0;
            bit_q    <= 4'h0;
            case (state_q)
              ST_DEV: begin
                if (rw_q) begin
                  state_q  <= ST_RD;
                  rdat_q   <= rd_byte;
                  o_sda_oe <= ~rd_byte[7];
                  addr_q   <= rd_next;
                end else begin
                  state_q <= ST_AH;
                end
              end
              ST_AH: state_q <= ST_AL;
              ST_AL: state_q <= ST_WD;
              ST_WD: state_q <= ST_WD;
              ST_RD: begin
                if (!mack_q) begin
                  rdat_q   <= rd_byte;
                  o_sda_oe <= ~rd_byte[7];
                  addr_q   <= rd_next;
                end else begin
                  state_q <= ST_IDLE;
                end
              end
              default: state_q <= ST_IDLE;
            endcase
          end
          default: begin
            // Shift the read byte out, MSB first
            if (state_q == ST_RD) begin
              o_sda_oe <= ~rdat_q[6];
              rdat_q   <= {rdat_q[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

  // Page buffer fill
  always @(posedge i_core_clk) begin
    if (i_ce && buf_we) begin
      pbuf[addr_q[6:0]] <= sh_q;
    end
  end

  // Commit buffered bytes to the array or id page
  always @(posedge i_core_clk) begin
    if (i_ce && cm_on && mask_q[ci]) begin
      if (id_q) begin
        idpg[ci] <= pbuf[ci];
      end else begin
        mem[{page_q, ci}] <= pbuf[ci];
      end
    end
  end

  // Lock is nonvolatile: reset does not clear it
  always @(posedge i_core_clk) begin
    if (i_ce && (state_q == ST_BUSY) && (cnt_q == 20'h00000) && lockp_q) begin
      o_id_locked <= 1'b1;
    end
  end

  // Delivery contents: blank array, preset id codes, unlocked
  initial begin
    o_id_locked = 1'b0;
    for (k = 0; k < 65536; k = k + 1) begin
      mem[k] = 8'hFF;
    end
    for (k = 0; k < 128; k = k + 1) begin
      idpg[k] = 8'hFF;
    end
    idpg[0] = `EIE_IDC_MFR;
    idpg[1] = `EIE_IDC_FAM;
    idpg[2] = `EIE_IDC_DEN;
  end

endmodule

`default_nettype wire

// ==== bench/eie_assertions.sv ====
/*
  Port checker for the EEPROM instruction engine.
  Assumes it is bound to eie_engine and shares its PROG_CYC.
*/
`timescale 1ns/1ns
`default_nettype none

module eie_chk #(
  parameter PROG_CYC = 200
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Pins and status
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_write_protect_input,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_busy,
  input wire logic o_id_locked
);
  int unsigned cnt_q;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // Length of the running program cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) cnt_q <= 0;
    else if (i_ce) cnt_q <= o_busy ? cnt_q + 1 : 0;
  end

  a_busy_quiet: assert property (o_busy |-> !o_sda_oe)
    else $error("data line driven while busy");
  a_drive_low: assert property (o_sda_oe |-> !o_sda_out)
    else $error("data line driven high");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("data changed while clock high");
  a_prog_on_stop: assert property ($rose(o_busy) |-> i_scl && i_sda)
    else $error("program cycle without stop");
  a_wp_blocks: assert property ($rose(o_busy) |-> !i_write_protect_input)
    else $error("program cycle under write protect");
  a_lock_kept: assert property (o_id_locked |=> o_id_locked)
    else $error("lock cleared");
  a_lock_in_prog: assert property ($rose(o_id_locked) |-> o_busy)
    else $error("lock outside program cycle");
  a_prog_len: assert property ($fell(o_busy) |-> cnt_q + 1 >= PROG_CYC && cnt_q <= PROG_CYC + 1)
    else $error("program cycle length wrong");
  a_prog_bound: assert property (o_busy |-> cnt_q <= PROG_CYC)
    else $error("program cycle too long");
endmodule

bind eie_engine eie_chk #(.PROG_CYC(PROG_CYC)) eie_chk_i (.i_core_clk, .i_rst, .i_ce, .i_scl, .i_sda,
  .i_write_protect_input, .o_sda_out, .o_sda_oe, .o_busy, .o_id_locked);

`default_nettype wire

// ==== bench/eie_master.sv ====
/*
  Two-wire bus master model: drives the serial clock, pulls data low.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none

module eie_master (
  // Bus lines
  output logic      o_scl,
  output logic      o_sda_pull,
  input  wire logic i_sda
);
  // Idle bus: clock rests high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // Start or repeated start
  task start;
    o_sda_pull = 1'b0;
    #160 o_scl = 1'b1;
    #160 o_sda_pull = 1'b1;
    #160 o_scl = 1'b0;
  endtask

  // Stop; clock then stands high
  task stop;
    o_sda_pull = 1'b1;
    #160 o_scl = 1'b1;
    #160 o_sda_pull = 1'b0;
    #160;
  endtask

  // One bit slot, data set while clock low, sampled mid-high
  task bit1(input logic b, output logic r);
    o_sda_pull = ~b;
    #160 o_scl = 1'b1;
    #80 r = i_sda;
    #80 o_scl = 1'b0;
  endtask

  // Byte out high bit first, ninth slot released
  task wr(input logic [7:0] dv, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(dv[i], r);
    bit1(1'b1, r);
    ack = ~r;
  endtask

  // Byte in; low in the ninth slot asks for more
  task rd(input logic more, output logic [7:0] dv);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(1'b1, dv[i]);
    bit1(~more, r);
  endtask
endmodule

`default_nettype wire

// ==== bench/eie_engine_tb_top.sv ====
/*
  Self-checking bench for eie_engine with a bus master model.
  Assumes a pull-up on the data line and a short program cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module eie_engine_tb_top;
  localparam int PC = 200;
  logic       i_core_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       wp = 1'b0;
  logic       ce = 1'b1;
  logic [2:0] cs = 3'h5;
  logic       scl, pull, oe, dout, busy, lkd, k;
  logic [7:0] d;
  int         err_count = 0, n_tests = 0, cyc = 0;
  wire        sda = ~pull & ~(oe & ~dout);

  eie_engine #(.PROG_CYC(PC)) eie_engine_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_ce(ce), .i_scl(scl), .i_sda(sda), .o_sda_out(dout), .o_sda_oe(oe),
    .i_write_protect_input(wp), .i_chip_select_bit2(cs[2]), .i_chip_select_bit1(cs[1]),
    .i_chip_select_bit0(cs[0]), .o_busy(busy), .o_id_locked(lkd));
  eie_master eie_master_i (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));

  // Core clock
  always #20 i_core_clk = ~i_core_clk;

  task chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task report_and_stop;
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [7:0] sel(input logic [3:0] t, input logic rw);
    return {t, cs, rw};
  endfunction

  // Start, write select and both address bytes
  task hd(input logic [3:0] t, input logic [15:0] a);
    eie_master_i.start();
    eie_master_i.wr(sel(t, 1'b0), k);
    chk(k, 1);
    eie_master_i.wr(a[15:8], k);
    chk(k, 1);
    eie_master_i.wr(a[7:0], k);
    chk(k, 1);
  endtask

  // Write n bytes, expect ack level ea, stop, then see busy follow
  task wrb(input logic [3:0] t, input logic [15:0] a, input logic [23:0] dq,
           input int n, input logic ea);
    hd(t, a);
    for (int i = 0; i < n; i++) begin
      eie_master_i.wr(dq[23-8*i -: 8], k);
      chk(k, ea);
    end
    eie_master_i.stop();
    repeat (10) @(posedge i_core_clk);
    chk(busy, ea);
  endtask

  // Optional address phase, then read n bytes
  task rdb(input logic [3:0] t, input logic [15:0] a, input logic cur,
           input logic [23:0] eq, input int n);
    if (!cur) hd(t, a);
    eie_master_i.start();
    eie_master_i.wr(sel(t, 1'b1), k);
    chk(k, 1);
    for (int i = 0; i < n; i++) begin
      eie_master_i.rd(i < n - 1, d);
      chk(d, eq[23-8*i -: 8]);
    end
    eie_master_i.stop();
    repeat (4) @(posedge i_core_clk);
    chk(oe, 0);
  endtask

  // Bounded wait for the program cycle to end
  task idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge i_core_clk);
    chk(busy, 0);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge i_core_clk);
    #1 i_rst = 1'b0;
    repeat (5) @(posedge i_core_clk);
    wrb(4'hA, 16'h0002, 24'h110000, 1, 1'b1);
    // Clock enable low freezes the program cycle counter
    @(posedge i_core_clk) #1 ce = 1'b0;
    repeat (300) @(posedge i_core_clk);
    chk(busy, 1);
    #1 ce = 1'b1;
    eie_master_i.start();
    eie_master_i.wr(sel(4'hA, 1'b0), k);
    chk(k, 0);
    eie_master_i.stop();
    idle();
    rdb(4'hA, 16'h0002, 1'b0, 24'h110000, 1);
    wrb(4'hA, 16'h007F, 24'hC0C1C2, 3, 1'b1);
    idle();
    rdb(4'hA, 16'h0000, 1'b1, 24'h110000, 1);
    rdb(4'hA, 16'hFFFF, 1'b0, 24'hFFC1C2, 3);
    rdb(4'hA, 16'h007F, 1'b0, 24'hC00000, 1);
    @(posedge i_core_clk) #1 wp = 1'b1;
    wrb(4'hA, 16'h0002, 24'h330000, 1, 1'b0);
    rdb(4'hA, 16'h0002, 1'b0, 24'h110000, 1);
    @(posedge i_core_clk) #1 wp = 1'b0;
    eie_master_i.start();
    eie_master_i.wr(sel(4'h9, 1'b0), k);
    chk(k, 0);
    eie_master_i.start();
    eie_master_i.wr({4'hA, ~cs, 1'b0}, k);
    chk(k, 0);
    eie_master_i.stop();
    rdb(4'hB, 16'hFF80, 1'b0, 24'h5A3C81, 3);
    hd(4'hB, 16'h0005);
    eie_master_i.wr(8'h44, k);
    chk(k, 1);
    eie_master_i.start();
    eie_master_i.stop();
    repeat (10) @(posedge i_core_clk);
    chk(busy, 0);
    wrb(4'hB, 16'hFB05, 24'h440000, 1, 1'b1);
    idle();
    rdb(4'hB, 16'h0085, 1'b0, 24'h440000, 1);
    wrb(4'hB, 16'h0400, 24'h020000, 1, 1'b1);
    idle();
    chk(lkd, 1);
    wrb(4'hB, 16'h0005, 24'h550000, 1, 1'b0);
    rdb(4'hB, 16'h0005, 1'b0, 24'h440000, 1);
    report_and_stop();
  end

  // Cycle ceiling against hangs
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      report_and_stop();
    end
  end
endmodule

`default_nettype wire
